// >>> bench/wpt_host_assertions.sv
// timing checks on the panel pins of the host
`timescale 1ns/1ps
`default_nettype none
module wpt_host_chk
	import wpt_pkg::*;
#(
	parameter logic [10:0] H_ACTIVE = 11'h320,
	parameter logic [10:0] H_SYNC   = 11'h014,
	parameter logic [10:0] H_START  = 11'h092,
	parameter logic [10:0] H_TOTAL  = 11'h420
) (
	input wire logic       dot_clk,
	input wire logic       rst_n,
	input wire logic       line_sync_n,
	input wire logic       frame_sync_n,
	input wire logic       active_video_flag,
	input wire logic [7:0] pixel_red,
	input wire logic [7:0] pixel_green,
	input wire logic [7:0] pixel_blue
);
	wpt_hcnt_t pos_r, low_r, act_r;
	logic      hs_q, seen_r;
	wire       hs_fall = hs_q && !line_sync_n;
	// seen_r masks the first line, which has no earlier sync to count from
	always_ff @(posedge dot_clk) begin
		hs_q   <= rst_n ? line_sync_n : 1'b1;
		seen_r <= rst_n && (seen_r || hs_fall);
		pos_r  <= (hs_fall || !rst_n) ? 11'h001 : pos_r + 11'h001;
		low_r  <= line_sync_n ? 11'h000 : low_r + 11'h001;
		act_r  <= active_video_flag ? act_r + 11'h001 : 11'h000;
	end
	default clocking @(posedge dot_clk); endclocking
	default disable iff (!rst_n);
	sync_width_a: assert property ($rose(line_sync_n) |-> low_r == H_SYNC)
		else $error("line sync width wrong");
	line_period_a: assert property (hs_fall && seen_r |-> pos_r == H_TOTAL)
		else $error("line period wrong");
	flag_width_a: assert property ($fell(active_video_flag) |-> act_r == H_ACTIVE)
		else $error("active flag width wrong");
	start_pos_a: assert property ($rose(active_video_flag) |-> pos_r == H_START)
		else $error("first pixel position wrong");
	front_porch_a: assert property ($fell(active_video_flag) |->
		pos_r == H_START + H_ACTIVE && H_TOTAL - pos_r >= 11'h06E)
		else $error("front porch wrong");
	sync_phase_a: assert property ($fell(frame_sync_n) |-> $fell(line_sync_n))
		else $error("frame sync not aligned");
	fsync_end_a: assert property ($rose(frame_sync_n) |-> $fell(line_sync_n))
		else $error("frame sync not whole lines");
	blank_black_a: assert property (!active_video_flag |->
		{pixel_red, pixel_green, pixel_blue} == 24'h00_0000)
		else $error("pixels not black in blanking");
endmodule
bind wpt_host wpt_host_chk #(.H_ACTIVE(H_ACTIVE), .H_SYNC(H_SYNC), .H_START(H_START),
	.H_TOTAL(H_TOTAL)) u_chk (.dot_clk(dot_clk), .rst_n(rst_n),
	.line_sync_n(line_sync_n), .frame_sync_n(frame_sync_n),
	.active_video_flag(active_video_flag), .pixel_red(pixel_red),
	.pixel_green(pixel_green), .pixel_blue(pixel_blue));
`default_nettype wire

// >>> bench/wpt_host_test.sv
// self-checking bench: host raster into behavioural panel
`timescale 1ns/1ps
`default_nettype none
`include "wpt_consts.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, s); end end
module wpt_host_test
	import wpt_pkg::*;
;
	logic        clk = 1'b0, dot_clk = 1'b0, rst_n = 1'b0, run_enable = 1'b0;
	logic        pix_valid = 1'b0, pix_ready, line_sync_n, frame_sync_n;
	logic        active_video_flag, display_live, underrun_seen;
	logic [23:0] pix_data = 24'h00_0000;
	logic [7:0]  pixel_red, pixel_green, pixel_blue;
	logic [15:0] frame_count;
	int          bad_count = 0, n_compared = 0, cyc = 0, j;
	// rows: word pushed, then {red, green, blue} the panel must see
	logic [23:0] row_in [12] = '{24'h00_0000, 24'hFF_0000, 24'h00_FF00, 24'hFF_FF00,
		24'h00_00FF, 24'hFF_00FF, 24'h00_FFFF, 24'hFF_FFFF, 24'h00_0001, 24'h00_0200,
		24'hFD_0000, 24'h00_00FE};
	logic [23:0] row_ex [12] = '{24'h00_0000, 24'h00_00FF, 24'h00_FF00, 24'h00_FFFF,
		24'hFF_0000, 24'hFF_00FF, 24'hFF_FF00, 24'hFF_FFFF, 24'h01_0000, 24'h00_0200,
		24'h00_00FD, 24'hFE_0000};
	// frame sync cut to two lines, back porch shortened so the run stays short
	wpt_host #(.V_SYNC(10'h002), .V_START(10'h004)) dut (.clk(clk), .rst_n(rst_n),
		.dot_clk(dot_clk), .run_enable(run_enable), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pix_data(pix_data), .line_sync_n(line_sync_n),
		.frame_sync_n(frame_sync_n), .active_video_flag(active_video_flag),
		.pixel_red(pixel_red), .pixel_green(pixel_green), .pixel_blue(pixel_blue),
		.display_live(display_live), .underrun_seen(underrun_seen),
		.frame_count(frame_count));
	wpt_panel_model u_panel (.dot_clock_in(dot_clk), .line_sync_n(line_sync_n),
		.frame_sync_n(frame_sync_n), .active_video_flag(active_video_flag),
		.rgb({pixel_red, pixel_green, pixel_blue}));
	// clocks: dot clock free-running, offset so edges never line up
	always #50 clk = ~clk;
	initial begin
		#13;
		forever #80 dot_clk = ~dot_clk;
	end
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// called at a falling dot edge; word is taken at the next rise with ready high
	task automatic push(input logic [23:0] w);
		pix_data = w;
		pix_valid = 1'b1;
		for (int i = 0; i < 99999 && pix_ready !== 1'b1; i++) @(negedge dot_clk);
		@(negedge dot_clk);
	endtask
	// hang guard, well above the six lines the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (5) @(negedge clk); // long enough for the dot side synchroniser
		`CHK("line_sync_n", 1'b1, line_sync_n)
		`CHK("frame_sync_n", 1'b1, frame_sync_n)
		`CHK("active_video_flag", 1'b0, active_video_flag)
		`CHK("pix_ready", 1'b0, pix_ready)
		`CHK("frame_count", 16'h0000, frame_count)
		rst_n = 1'b1;
		fork
			begin
				@(negedge dot_clk);
				for (int r = 0; r < 12; r++) push(row_in[r]);
				pix_valid = 1'b0;
			end
		join_none
		repeat (10) @(negedge dot_clk);
		`CHK("pix_ready when full", 1'b0, pix_ready)
		@(negedge clk);
		run_enable = 1'b1;
		for (j = 0; j < 19000 && u_panel.ln < 6; j++) @(negedge clk);
		if (j == 19000) bad_count++; // a raster that never reaches line six fails
		for (j = 0; j < 12; j++) `CHK("pixel", row_ex[j], u_panel.mem[j])
		`CHK("pixel after underrun", 24'h00_0000, u_panel.mem[12])
		`CHK("underrun_seen", 1'b1, underrun_seen)
		`CHK("line length", `WPT_H_TOTAL, u_panel.ll)
		`CHK("sync width", `WPT_H_SYNC, u_panel.sl)
		`CHK("first pixel", `WPT_H_START, u_panel.st)
		`CHK("flag width", 800, u_panel.fl)
		`CHK("front porch", 110, u_panel.ll - u_panel.st - u_panel.fl)
		`CHK("frame sync lines", 2, u_panel.vw)
		`CHK("first active line", 4, u_panel.fst)
		`CHK("pixels in two lines", 1600, u_panel.n)
		`CHK("frame_count", 16'h0001, frame_count)
		`CHK("display_live", 1'b0, display_live)
		`CHK("panel showing", 1'b0, u_panel.showing)
		give_verdict;
	end
endmodule
`default_nettype wire

// >>> bench/wpt_panel_model.sv
// behavioural panel: samples the pixel pins and measures the raster
`timescale 1ns/1ps
`default_nettype none
module wpt_panel_model (
	input wire logic        dot_clock_in,
	input wire logic        line_sync_n,
	input wire logic        frame_sync_n,
	input wire logic        active_video_flag,
	input wire logic [23:0] rgb
);
	logic        ls_q = 1'b1, fs_q = 1'b1, av_q = 1'b0;
	int          h = 0, ll = 0, sw = 0, sl = 0, st = 0, fw = 0, fl = 0;
	int          ln = 0, vl = 0, vw = 0, fst = -1, n = 0, falls = 0;
	logic [23:0] mem [16];
	wire         showing = falls >= 9;
	// no reset: the panel only knows power-up, so counters start at zero
	always @(posedge dot_clock_in) begin
		ls_q <= line_sync_n;
		fs_q <= frame_sync_n;
		av_q <= active_video_flag;
		h <= (ls_q && !line_sync_n) ? 0 : h + 1;
		sw <= line_sync_n ? 0 : sw + 1;
		fw <= active_video_flag ? fw + 1 : 0;
		if (!ls_q && line_sync_n) sl <= sw;
		if (av_q && !active_video_flag) fl <= fw;
		if (ls_q && !line_sync_n) begin
			ll <= h + 1;
			ln <= ln + 1;
			if (!frame_sync_n) vl <= vl + 1;
		end
		if (!fs_q && frame_sync_n) vw <= vl;
		if (fs_q && !frame_sync_n) begin
			falls <= falls + 1;
			ln <= 0;
			vl <= 1;
		end
		// start of pixels comes from the flag only; blanking clocks are ignored
		if (!av_q && active_video_flag) st <= h + 1;
		if (!av_q && active_video_flag && fst < 0) fst <= ln;
		if (active_video_flag) begin
			if (n < 16) mem[n] <= rgb;
			n <= n + 1;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/wpt_consts.svh
// timing constants and limits for the wvga panel timing host
`ifndef WPT_CONSTS_SVH
`define WPT_CONSTS_SVH

// horizontal timing in dot clocks, counted from line sync start
`define WPT_H_ACTIVE      11'h320
`define WPT_H_SYNC        11'h014
`define WPT_H_START       11'h092
`define WPT_H_TOTAL       11'h420
`define WPT_H_SYNC_MIN    11'h005
`define WPT_H_START_MIN   11'h014
`define WPT_H_START_MAX   11'h0B2
`define WPT_H_FP_MIN      11'h06E
`define WPT_H_TOTAL_MIN   11'h400
`define WPT_H_TOTAL_MAX   11'h440

// vertical timing in lines, counted from frame sync start
`define WPT_V_ACTIVE      10'h1E0
`define WPT_V_SYNC        10'h003
`define WPT_V_START       10'h01F
`define WPT_V_TOTAL       10'h20D
`define WPT_V_SYNC_MIN    10'h002
`define WPT_V_FP_MIN      10'h005
`define WPT_V_TOTAL_MIN   10'h208
`define WPT_V_TOTAL_MAX   10'h212

// frame sync falls before the panel shows images
`define WPT_LIVE_FRAMES   4'h9

// pixel word layout
`define WPT_PIX_W         24
`define WPT_BLACK         24'h00_0000

`endif

// >>> rtl/wpt_host.sv
// display timing host: raster generator driving the panel pixel pins
`timescale 1ns/1ps
`default_nettype none
`include "wpt_consts.svh"
module wpt_host
	import wpt_pkg::*;
#(
	parameter logic [10:0] H_ACTIVE = `WPT_H_ACTIVE,
	parameter logic [10:0] H_SYNC   = `WPT_H_SYNC,
	parameter logic [10:0] H_START  = `WPT_H_START,
	parameter logic [10:0] H_TOTAL  = `WPT_H_TOTAL,
	parameter logic [9:0]  V_ACTIVE = `WPT_V_ACTIVE,
	parameter logic [9:0]  V_SYNC   = `WPT_V_SYNC,
	parameter logic [9:0]  V_START  = `WPT_V_START,
	parameter logic [9:0]  V_TOTAL  = `WPT_V_TOTAL,
	parameter int          BUF_DEPTH = 2
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        dot_clk,
	input  wire logic        run_enable,
	input  wire logic        pix_valid,
	output logic             pix_ready,
	input  wire logic [23:0] pix_data,
	output logic             line_sync_n,
	output logic             frame_sync_n,
	output logic             active_video_flag,
	output logic [7:0]       pixel_red,
	output logic [7:0]       pixel_green,
	output logic [7:0]       pixel_blue,
	output logic             display_live,
	output logic             underrun_seen,
	output logic [15:0]      frame_count
);
	// refuse timings the panel cannot take
	generate
		if (H_SYNC < `WPT_H_SYNC_MIN || H_SYNC > H_START) begin : g_bad_hsync
			$error("wpt_host: line sync width out of range");
		end
		if (H_START < `WPT_H_START_MIN || H_START > `WPT_H_START_MAX) begin : g_bad_hbp
			$error("wpt_host: horizontal back porch out of range");
		end
		if (H_TOTAL < `WPT_H_TOTAL_MIN || H_TOTAL > `WPT_H_TOTAL_MAX) begin : g_bad_htot
			$error("wpt_host: line total out of range");
		end
		if (H_TOTAL < H_START + H_ACTIVE + `WPT_H_FP_MIN) begin : g_bad_hfp
			$error("wpt_host: horizontal front porch too short");
		end
		if (V_SYNC < `WPT_V_SYNC_MIN || V_SYNC > V_START) begin : g_bad_vsync
			$error("wpt_host: frame sync width out of range");
		end
		if (V_TOTAL < `WPT_V_TOTAL_MIN || V_TOTAL > `WPT_V_TOTAL_MAX) begin : g_bad_vtot
			$error("wpt_host: frame total out of range");
		end
		if (V_TOTAL < V_START + V_ACTIVE + `WPT_V_FP_MIN) begin : g_bad_vfp
			$error("wpt_host: vertical front porch too short");
		end
		if (H_ACTIVE != `WPT_H_ACTIVE || V_ACTIVE != `WPT_V_ACTIVE) begin : g_bad_area
			$error("wpt_host: active area must be 800 by 480");
		end
	endgenerate

	// true while cnt lies in [start, start+len)
	function automatic logic in_window(
		input logic [10:0] cnt,
		input logic [10:0] start,
		input logic [10:0] len
	);
		logic [11:0] stop;
		stop = {1'b0, start} + {1'b0, len};
		in_window = (cnt >= start) && ({1'b0, cnt} < stop);
	endfunction

	// true while cnt has not yet reached lim; serves both sync pulses
	function automatic logic below(
		input logic [10:0] cnt,
		input logic [10:0] lim
	);
		below = (cnt < lim);
	endfunction

	// control domain (clk); status, plus the run_enable flop the raster waits on to start and stop

	logic        run_req_r;
	logic        frame_s1_r;
	logic        frame_s2_r;
	logic        frame_s3_r;
	logic        und_s1_r;
	logic        und_s2_r;
	logic        und_s3_r;
	logic [3:0]  live_cnt_r;
	logic [3:0]  live_cnt_nxt;
	logic        display_live_r;
	logic        underrun_seen_r;
	logic        underrun_seen_nxt;
	logic [15:0] frame_count_r;
	// toggles launched on the link side, read here through two flops
	logic        frame_tgl_r;
	logic        und_tgl_r;

	// events arrive as toggles; compare the two settled stages only
	wire frame_evt = frame_s2_r ^ frame_s3_r;
	wire und_evt   = und_s2_r ^ und_s3_r;

	// saturating count of frame sync falls since reset
	assign live_cnt_nxt = (frame_evt && live_cnt_r != `WPT_LIVE_FRAMES) ?
		live_cnt_r + 4'h1 : live_cnt_r;
	// a new underrun wins over the clear by a low enable
	assign underrun_seen_nxt = und_evt || (underrun_seen_r && run_req_r);

	// event synchronisers; the second and third stages are read, the first only by the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_req_r  <= 1'b0;
			frame_s1_r <= 1'b0;
			frame_s2_r <= 1'b0;
			frame_s3_r <= 1'b0;
			und_s1_r   <= 1'b0;
			und_s2_r   <= 1'b0;
			und_s3_r   <= 1'b0;
		end else begin
			run_req_r  <= run_enable;
			frame_s1_r <= frame_tgl_r;
			frame_s2_r <= frame_s1_r;
			frame_s3_r <= frame_s2_r;
			und_s1_r   <= und_tgl_r;
			und_s2_r   <= und_s1_r;
			und_s3_r   <= und_s2_r;
		end
	end

	// status flops; the frame count wraps, the live flag never falls
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			live_cnt_r      <= 4'h0;
			display_live_r  <= 1'b0;
			underrun_seen_r <= 1'b0;
			frame_count_r   <= 16'h0000;
		end else begin
			live_cnt_r      <= live_cnt_nxt;
			display_live_r  <= (live_cnt_nxt == `WPT_LIVE_FRAMES);
			underrun_seen_r <= underrun_seen_nxt;
			if (frame_evt) begin
				frame_count_r <= frame_count_r + 16'h0001;
			end
		end
	end

	// status pins straight from their flops
	assign display_live  = display_live_r;
	assign underrun_seen = underrun_seen_r;
	assign frame_count   = frame_count_r;

	// link domain (dot_clk)

	logic       dot_rst_s1_r;
	logic       dot_rst_n_r;
	logic       run_s1_r;
	logic       run_s2_r;
	wpt_state_e state_r;
	wpt_state_e state_nxt;
	wpt_hcnt_t  h_cnt_r;
	wpt_hcnt_t  h_cnt_nxt;
	wpt_vcnt_t  v_cnt_r;
	wpt_vcnt_t  v_cnt_nxt;
	logic       de_nxt;
	logic       line_sync_n_r;
	logic       frame_sync_n_r;
	logic       active_r;
	logic [23:0] pixel_r;
	logic       buf_valid;
	logic [23:0] buf_data;

	// stalls the source whenever the buffer is full
	// depth two covers the one-clock lag of the registered ready
	wpt_pix_buf #(
		.WIDTH (`WPT_PIX_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk       (dot_clk),
		.rst_n     (dot_rst_n_r),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.in_data   (pix_data),
		.out_valid (buf_valid),
		.out_ready (de_nxt),
		.out_data  (buf_data)
	);

	// raster position and phase decode
	wire running    = (state_r == WPT_ST_RUN);
	wire h_last     = (h_cnt_r == H_TOTAL - 11'h001);
	wire v_last     = (v_cnt_r == V_TOTAL - 10'h001);
	wire frame_end  = h_last && v_last;
	wire hs_nxt     = running && below(h_cnt_r, H_SYNC);
	wire vs_nxt     = running && below({1'b0, v_cnt_r}, {1'b0, V_SYNC});
	wire h_act      = in_window(h_cnt_r, H_START, H_ACTIVE);
	wire v_act      = in_window({1'b0, v_cnt_r}, {1'b0, V_START},
		{1'b0, V_ACTIVE});
	assign de_nxt   = running && h_act && v_act;
	wire frame_start = running && (h_cnt_r == 11'h000) && (v_cnt_r == 10'h000);
	// an underrun slips the image: no word is dropped to catch up
	wire underrun   = de_nxt && !buf_valid;
	// blanking and underrun carry black, never stale data
	wire [23:0] pix_nxt = (de_nxt && buf_valid) ? buf_data : `WPT_BLACK;

	// start only at a frame boundary and stop only after a whole frame
	// counters hold at zero while idle so a restart begins a clean frame
	always_comb begin
		state_nxt = state_r;
		h_cnt_nxt = h_cnt_r;
		v_cnt_nxt = v_cnt_r;
		case (state_r)
			WPT_ST_IDLE: begin
				h_cnt_nxt = 11'h000;
				v_cnt_nxt = 10'h000;
				if (run_s2_r) begin
					state_nxt = WPT_ST_RUN;
				end
			end
			WPT_ST_RUN: begin
				h_cnt_nxt = h_last ? 11'h000 : h_cnt_r + 11'h001;
				if (h_last) begin
					v_cnt_nxt = v_last ? 10'h000 : v_cnt_r + 10'h001;
				end
				if (frame_end && !run_s2_r) begin
					state_nxt = WPT_ST_IDLE;
				end
			end
			default: begin
				state_nxt = WPT_ST_IDLE;
			end
		endcase
	end

	// the link side leaves reset two dot clocks after rst_n rises
	// reset crossing into the link domain; no reset on these two
	always_ff @(posedge dot_clk) begin
		dot_rst_s1_r <= rst_n;
		dot_rst_n_r  <= dot_rst_s1_r;
	end

	// enable synchroniser; a drop takes effect only at the end of a frame
	always_ff @(posedge dot_clk) begin
		if (!dot_rst_n_r) begin
			run_s1_r <= 1'b0;
			run_s2_r <= 1'b0;
		end else begin
			run_s1_r <= run_req_r;
			run_s2_r <= run_s1_r;
		end
	end

	// raster state; the dot clock is never gated, so lines stay even
	always_ff @(posedge dot_clk) begin
		if (!dot_rst_n_r) begin
			state_r <= WPT_ST_IDLE;
			h_cnt_r <= 11'h000;
			v_cnt_r <= 10'h000;
		end else begin
			state_r <= state_nxt;
			h_cnt_r <= h_cnt_nxt;
			v_cnt_r <= v_cnt_nxt;
		end
	end

	// events leave as toggles; back-to-back underruns may merge,
	// which the sticky flag tolerates
	always_ff @(posedge dot_clk) begin
		if (!dot_rst_n_r) begin
			frame_tgl_r <= 1'b0;
			und_tgl_r   <= 1'b0;
		end else begin
			if (frame_start) begin
				frame_tgl_r <= ~frame_tgl_r;
			end
			if (underrun) begin
				und_tgl_r <= ~und_tgl_r;
			end
		end
	end

	// pin flops: both syncs change on the same dot clock edge
	// outputs come straight from these flops; no decode after them
	always_ff @(posedge dot_clk) begin
		if (!dot_rst_n_r) begin
			line_sync_n_r  <= 1'b1;
			frame_sync_n_r <= 1'b1;
			active_r       <= 1'b0;
			pixel_r        <= `WPT_BLACK;
		end else begin
			line_sync_n_r  <= ~hs_nxt;
			frame_sync_n_r <= ~vs_nxt;
			active_r       <= de_nxt;
			pixel_r        <= pix_nxt;
		end
	end

	// bit 0 of each colour is the least significant
	assign line_sync_n       = line_sync_n_r;
	assign frame_sync_n      = frame_sync_n_r;
	assign active_video_flag = active_r;
	assign pixel_red         = pixel_r[7:0];
	assign pixel_green       = pixel_r[15:8];
	assign pixel_blue        = pixel_r[23:16];
endmodule
`default_nettype wire

// >>> rtl/wpt_pix_buf.sv
// small pixel fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module wpt_pix_buf #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("wpt_pix_buf: DEPTH must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             in_ready_r;
	wire              push = in_valid && in_ready_r;
	wire              pop  = out_valid && out_ready;

	// ready is registered so the top sees it straight from a flop
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready  = in_ready_r;
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];

	// storage and pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			count_r    <= '0;
			in_ready_r <= 1'b0;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data;
				wr_ptr_r        <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt < (AW+1)'(DEPTH));
		end
	end
endmodule
`default_nettype wire

// >>> rtl/wpt_pkg.sv
// types shared by the wvga panel timing host
package wpt_pkg;
	typedef enum logic {
		WPT_ST_IDLE,
		WPT_ST_RUN
	} wpt_state_e;
	typedef logic [10:0] wpt_hcnt_t;
	typedef logic [9:0]  wpt_vcnt_t;
endpackage
